// *** rtl/rxgl_pkg.sv ***
// register map, field layout, reset values and timing for the rx loops
package rxgl_pkg;
	localparam int          CLK_HZ          = 200_000_000;
	localparam int          TICK_CLKS       = 12;
	localparam logic [5:0]  OFS_FL_GAIN     = 6'h00;
	localparam logic [5:0]  OFS_FL_PERIOD   = 6'h04;
	localparam logic [5:0]  OFS_FL_MODE     = 6'h08;
	localparam logic [5:0]  OFS_RX_CFG      = 6'h0C;
	localparam logic [5:0]  OFS_GL_HIGH     = 6'h10;
	localparam logic [5:0]  OFS_GL_LOW      = 6'h14;
	localparam logic [5:0]  OFS_GL_CTRL     = 6'h18;
	localparam logic [5:0]  OFS_FL_EST      = 6'h1C;
	localparam logic [5:0]  OFS_STATUS      = 6'h20;
	localparam int          POS_FAST_GAIN   = 4;
	localparam int          POS_SLOW_GAIN   = 0;
	localparam int          POS_FL_EN       = 0;
	localparam int          POS_FL_MODE     = 1;
	localparam int          POS_MOD         = 0;
	localparam int          POS_RSSI_START_THRESHOLD     = 8;
	localparam int          POS_HIGH_TH     = 0;
	localparam int          POS_MEAS_EXP    = 4;
	localparam int          POS_LOW0        = 0;
	localparam int          POS_LOW1        = 4;
	localparam int          POS_LOW_SEL     = 8;
	localparam int          POS_HOLD        = 0;
	localparam int          POS_GL_EN       = 8;
	localparam int          POS_FREEZE      = 9;
	localparam logic [3:0]  RST_FAST_GAIN   = 4'h2;
	localparam logic [3:0]  RST_SLOW_GAIN   = 4'h5;
	localparam logic [7:0]  RST_FAST_PERIOD = 8'h10;
	localparam logic [7:0]  RST_RSSI_START_THRESHOLD     = 8'h40;
	localparam logic [3:0]  RST_HIGH_TH     = 4'h5;
	localparam logic [3:0]  RST_MEAS_EXP    = 4'h2;
	localparam logic [3:0]  RST_LOW0        = 4'h5;
	localparam logic [3:0]  RST_LOW1        = 4'h4;
	localparam logic [7:0]  RST_LOW_SEL     = 8'h10;
	localparam logic [7:0]  RST_HOLD        = 8'h0C;
	localparam logic [3:0]  MAX_ATTEN_STEP  = 4'h8;
	typedef enum logic [2:0]
	{
		RXGL_MOD_2FSK  = 3'h0,
		RXGL_MOD_4FSK  = 3'h1,
		RXGL_MOD_2GFSK = 3'h2,
		RXGL_MOD_4GFSK = 3'h3,
		RXGL_MOD_ASK   = 3'h4
	} rxgl_mod_t;
	typedef enum logic [2:0]
	{
		RXGL_F_IDLE = 3'b001,
		RXGL_F_FAST = 3'b010,
		RXGL_F_SLOW = 3'b100
	} rxgl_fstate_t;
	typedef enum logic [1:0]
	{
		RXGL_G_HOLD = 2'b01,
		RXGL_G_MEAS = 2'b10
	} rxgl_gstate_t;
endpackage

// *** rtl/rxgl_loops.sv ***
// receive frequency offset and gain control loops with register slave
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// What this block does
// - frequency loop runs only for fsk modulations, idle for amplitude modulation
// - track min and max demodulated frequency, correction is their midpoint
// - mode bit 0 corrects at slicer, 1 retunes second if
// - frequency error estimate readable, lsb fdig over 3 times 2^13
// - fast phase starts when rssi exceeds threshold, slow after a period
// - fast and slow log2 gains 0..15 chosen by current phase
// - fast period in samples 0..255, zero switches at sync detect
// - frequency loop enable, disabled applies no correction
// - attenuation moves in 6 db steps up to 48 db
// - peak amplitude compared with high and low thresholds
// - high threshold 0..15, reset 0x5
// - two low thresholds, per-step select bits choose one
// - measure lasts 12 clocks times 2^exponent, decrease only if always low
// - measure exponent resets to 0x2
// - hold of 12 clocks times hold count after each change
// - above high threshold no measure, increase every hold interval
// - below low threshold decrease every measure plus hold interval
// - loop repeats, attenuation steady between thresholds
// - freeze on sync stops attenuation changes after sync word
// - gain loop enable, disabled leaves attenuation unchanged
module rxgl_loops
	import rxgl_pkg::*;
#(
	parameter int FREQ_W = 12,
	parameter int AMP_W  = 4
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [5:0]        avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic [FREQ_W-1:0] freq_sample_i,
	input  wire logic              freq_valid_i,
	input  wire logic [7:0]        rssi_i,
	input  wire logic              sync_det_i,
	input  wire logic [AMP_W-1:0]  peak_amp_i,
	output logic [FREQ_W-1:0]      slicer_offset_o,
	output logic [FREQ_W-1:0]      if2_offset_o,
	output logic [3:0]             atten_step_o
);
	// widths outside this range break the read mux and comparators
	if (FREQ_W < 8 || FREQ_W > 16 || AMP_W < 4 || AMP_W > 8)
	begin : g_bad_width
		$error("rxgl_loops: unsupported width");
	end

	// register storage
	logic [3:0]  fast_gain_r;
	logic [3:0]  slow_gain_r;
	logic [7:0]  fast_period_r;
	logic        fl_en_r;
	logic        fl_mode_r;
	logic [2:0]  mod_r;
	logic [7:0]  rssi_start_threshold_r;
	logic [3:0]  high_th_r;
	logic [3:0]  meas_exp_r;
	logic [3:0]  low0_r;
	logic [3:0]  low1_r;
	logic [7:0]  low_sel_r;
	logic [7:0]  hold_r;
	logic        gl_en_r;
	logic        freeze_r;
	logic        ack_r;
	logic        req;
	logic        wr_go;
	logic [31:0] rd_nxt;

	assign req               = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & ~ack_r;
	assign wr_go             = avs_write_i & ack_r;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			fast_gain_r   <= RST_FAST_GAIN;
			slow_gain_r   <= RST_SLOW_GAIN;
			fast_period_r <= RST_FAST_PERIOD;
			fl_en_r       <= 1'b0;
			fl_mode_r     <= 1'b0;
			mod_r         <= RXGL_MOD_2FSK;
			rssi_start_threshold_r     <= RST_RSSI_START_THRESHOLD;
			high_th_r     <= RST_HIGH_TH;
			meas_exp_r    <= RST_MEAS_EXP;
			low0_r        <= RST_LOW0;
			low1_r        <= RST_LOW1;
			low_sel_r     <= RST_LOW_SEL;
			hold_r        <= RST_HOLD;
			gl_en_r       <= 1'b0;
			freeze_r      <= 1'b0;
		end
		else if (wr_go && avs_byteenable_i[0])
		begin
			case (avs_address_i)
				OFS_FL_GAIN:
				begin
					fast_gain_r <= avs_writedata_i[POS_FAST_GAIN +: 4];
					slow_gain_r <= avs_writedata_i[POS_SLOW_GAIN +: 4];
				end
				OFS_FL_PERIOD: fast_period_r <= avs_writedata_i[7:0];
				OFS_FL_MODE:
				begin
					fl_en_r   <= avs_writedata_i[POS_FL_EN];
					fl_mode_r <= avs_writedata_i[POS_FL_MODE];
				end
				OFS_RX_CFG: mod_r <= avs_writedata_i[POS_MOD +: 3];
				OFS_GL_HIGH:
				begin
					high_th_r  <= avs_writedata_i[POS_HIGH_TH +: 4];
					meas_exp_r <= avs_writedata_i[POS_MEAS_EXP +: 4];
				end
				OFS_GL_LOW:
				begin
					low0_r <= avs_writedata_i[POS_LOW0 +: 4];
					low1_r <= avs_writedata_i[POS_LOW1 +: 4];
				end
				OFS_GL_CTRL: hold_r <= avs_writedata_i[POS_HOLD +: 8];
				default:
				begin
				end
			endcase
		end
		else if (wr_go && avs_byteenable_i[1])
		begin
			case (avs_address_i)
				OFS_RX_CFG: rssi_start_threshold_r <= avs_writedata_i[POS_RSSI_START_THRESHOLD +: 8];
				OFS_GL_LOW: low_sel_r <= avs_writedata_i[POS_LOW_SEL +: 8];
				OFS_GL_CTRL:
				begin
					gl_en_r  <= avs_writedata_i[POS_GL_EN];
					freeze_r <= avs_writedata_i[POS_FREEZE];
				end
				default:
				begin
				end
			endcase
		end
	end

	// frequency loop
	rxgl_fstate_t            fst_r;
	logic signed [FREQ_W-1:0] fmin_r;
	logic signed [FREQ_W-1:0] fmax_r;
	logic signed [FREQ_W-1:0] corr_r;
	logic signed [FREQ_W:0]   mid;
	logic signed [FREQ_W:0]   err;
	logic [7:0]              fcnt_r;
	logic [3:0]              gain;
	logic                    fsk;
	logic                    fl_run;

	assign fsk    = (mod_r != RXGL_MOD_ASK) && (mod_r <= RXGL_MOD_4GFSK);
	assign fl_run = fl_en_r && fsk;
	assign gain   = (fst_r == RXGL_F_FAST) ? fast_gain_r : slow_gain_r;
	assign mid    = ($signed({fmin_r[FREQ_W-1], fmin_r}) + $signed({fmax_r[FREQ_W-1], fmax_r}))
	                >>> 1;
	assign err    = mid - $signed({corr_r[FREQ_W-1], corr_r});

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			fst_r  <= RXGL_F_IDLE;
			fcnt_r <= 8'h00;
		end
		else if (!fl_run)
			fst_r <= RXGL_F_IDLE;
		else
		begin
			case (fst_r)
				RXGL_F_IDLE:
				begin
					fcnt_r <= 8'h00;
					if (rssi_i > rssi_start_threshold_r)
						fst_r <= RXGL_F_FAST;
				end
				RXGL_F_FAST:
				begin
					if (fast_period_r == 8'h00)
					begin
						if (sync_det_i)
							fst_r <= RXGL_F_SLOW;
					end
					else if (freq_valid_i)
					begin
						fcnt_r <= fcnt_r + 8'h01;
						if (fcnt_r + 8'h01 >= fast_period_r)
							fst_r <= RXGL_F_SLOW;
					end
				end
				RXGL_F_SLOW: fst_r <= RXGL_F_SLOW;
				default: fst_r <= RXGL_F_IDLE;
			endcase
		end
	end

	// min/max tracking with slow leak toward the centre
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			fmin_r <= '0;
			fmax_r <= '0;
			corr_r <= '0;
		end
		else if (fst_r == RXGL_F_IDLE)
		begin
			fmin_r <= corr_r;
			fmax_r <= corr_r;
		end
		else if (freq_valid_i)
		begin
			if ($signed(freq_sample_i) < fmin_r)
				fmin_r <= $signed(freq_sample_i);
			else
				fmin_r <= fmin_r + ((corr_r - fmin_r) >>> 6);
			if ($signed(freq_sample_i) > fmax_r)
				fmax_r <= $signed(freq_sample_i);
			else
				fmax_r <= fmax_r - ((fmax_r - corr_r) >>> 6);
			corr_r <= corr_r + FREQ_W'(err >>> gain);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			slicer_offset_o <= '0;
			if2_offset_o    <= '0;
		end
		else
		begin
			slicer_offset_o <= (fl_run && !fl_mode_r) ? corr_r : '0;
			if2_offset_o    <= (fl_run && fl_mode_r) ? corr_r : '0;
		end
	end

	// gain loop timers
	rxgl_gstate_t gst_r;
	logic [3:0]  tick_cnt_r;
	logic        tick;
	logic [15:0] meas_cnt_r;
	logic [7:0]  hold_cnt_r;
	logic        below_r;
	logic        frozen_r;
	logic        gl_act;
	logic        above;
	logic        below;
	logic [3:0]  low_th;
	logic        up;
	logic        down;
	logic [15:0] meas_len;

	assign tick     = (tick_cnt_r == 4'(TICK_CLKS - 1));
	assign meas_len = 16'h0001 << meas_exp_r;
	assign gl_act   = gl_en_r && !frozen_r;
	assign low_th   = low_sel_r[atten_step_o[2:0]] ? low1_r : low0_r;
	assign above    = peak_amp_i > AMP_W'(high_th_r);
	assign below    = peak_amp_i < AMP_W'(low_th);
	assign up       = gl_act && gst_r == RXGL_G_MEAS && above
	                  && atten_step_o < MAX_ATTEN_STEP;
	assign down     = gl_act && gst_r == RXGL_G_MEAS && !above && tick
	                  && meas_cnt_r + 16'h0001 >= meas_len && below_r && below
	                  && atten_step_o != 4'h0;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			frozen_r <= 1'b0;
		else if (!gl_en_r || !freeze_r)
			frozen_r <= 1'b0;
		else if (sync_det_i)
			frozen_r <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || up || down)
			tick_cnt_r <= 4'h0;
		else if (tick)
			tick_cnt_r <= 4'h0;
		else
			tick_cnt_r <= tick_cnt_r + 4'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			gst_r      <= RXGL_G_HOLD;
			hold_cnt_r <= 8'h00;
			meas_cnt_r <= 16'h0000;
			below_r    <= 1'b1;
		end
		else if (up || down || !gl_act)
		begin
			gst_r      <= RXGL_G_HOLD;
			hold_cnt_r <= 8'h00;
			meas_cnt_r <= 16'h0000;
			below_r    <= 1'b1;
		end
		else
		begin
			case (gst_r)
				RXGL_G_HOLD:
				begin
					if (hold_cnt_r >= hold_r)
						gst_r <= RXGL_G_MEAS;
					else if (tick)
						hold_cnt_r <= hold_cnt_r + 8'h01;
				end
				RXGL_G_MEAS:
				begin
					if (!below)
						below_r <= 1'b0;
					if (tick)
					begin
						if (meas_cnt_r + 16'h0001 >= meas_len)
						begin
							meas_cnt_r <= 16'h0000;
							below_r    <= 1'b1;
						end
						else
							meas_cnt_r <= meas_cnt_r + 16'h0001;
					end
				end
				default: gst_r <= RXGL_G_HOLD;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			atten_step_o <= 4'h0;
		else if (up)
			atten_step_o <= atten_step_o + 4'h1;
		else if (down)
			atten_step_o <= atten_step_o - 4'h1;
	end

	// read mux
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		case (avs_address_i)
			OFS_FL_GAIN:   rd_nxt = {24'h0, fast_gain_r, slow_gain_r};
			OFS_FL_PERIOD: rd_nxt = {24'h0, fast_period_r};
			OFS_FL_MODE:   rd_nxt = {30'h0, fl_mode_r, fl_en_r};
			OFS_RX_CFG:    rd_nxt = {16'h0, rssi_start_threshold_r, 5'h0, mod_r};
			OFS_GL_HIGH:   rd_nxt = {24'h0, meas_exp_r, high_th_r};
			OFS_GL_LOW:    rd_nxt = {16'h0, low_sel_r, low1_r, low0_r};
			OFS_GL_CTRL:   rd_nxt = {22'h0, freeze_r, gl_en_r, hold_r};
			OFS_FL_EST:    rd_nxt = 32'($signed(corr_r));
			OFS_STATUS:    rd_nxt = {24'h0, frozen_r, fst_r, atten_step_o};
			default:       rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && !ack_r)
			avs_readdata_o <= rd_nxt;
	end
endmodule // rxgl_loops

// *** verification/rxgl_loops_monitor.sv ***
// port checker for the rx gain and frequency loops
`timescale 1ns/10ps
module rxgl_loops_monitor
	import rxgl_pkg::*;
#(
	parameter int FREQ_W = 12,
	parameter int AMP_W  = 4
)
(
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic [5:0]        avs_address_i,
	input wire logic              avs_read_i,
	input wire logic              avs_write_i,
	input wire logic [31:0]       avs_writedata_i,
	input wire logic [3:0]        avs_byteenable_i,
	input wire logic [31:0]       avs_readdata_o,
	input wire logic              avs_waitrequest_o,
	input wire logic [FREQ_W-1:0] freq_sample_i,
	input wire logic              freq_valid_i,
	input wire logic [7:0]        rssi_i,
	input wire logic              sync_det_i,
	input wire logic [AMP_W-1:0]  peak_amp_i,
	input wire logic [FREQ_W-1:0] slicer_offset_o,
	input wire logic [FREQ_W-1:0] if2_offset_o,
	input wire logic [3:0]        atten_step_o
);
	wire req = avs_read_i | avs_write_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_up;
		atten_step_o == $past(atten_step_o) + 4'h1;
	endsequence
	sequence s_dn;
		atten_step_o == $past(atten_step_o) - 4'h1;
	endsequence
	a_wait_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("no answer after one wait cycle");
	a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
		else $error("wait without request");
	a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
		&& avs_address_i > OFS_STATUS |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_atten_max: assert property (atten_step_o <= MAX_ATTEN_STEP)
		else $error("attenuation above top step");
	a_atten_unit: assert property ($changed(atten_step_o) |-> s_up or s_dn)
		else $error("attenuation moved more than one step");
	a_atten_gap: assert property ($changed(atten_step_o) |=> $stable(atten_step_o)[*8])
		else $error("attenuation changed inside hold");
	a_rise_cause: assert property (s_up |-> $past(peak_amp_i) != '0)
		else $error("increase without high amplitude");
	a_fall_cause: assert property (s_dn |-> $past(peak_amp_i) != {AMP_W{1'b1}})
		else $error("decrease at full amplitude");
	a_offset_one: assert property (slicer_offset_o == '0 || if2_offset_o == '0)
		else $error("both correction paths active");
endmodule // rxgl_loops_monitor

bind rxgl_loops rxgl_loops_monitor #(.FREQ_W(FREQ_W), .AMP_W(AMP_W)) mon_u (.*);

// *** verification/rxgl_rf_model.sv ***
// analog front end model: attenuated peak amplitude and demodulated tones
`timescale 1ns/10ps
module rxgl_rf_model
	import rxgl_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [3:0]  atten_step_i,
	input  wire logic [7:0]  level_i,
	input  wire logic [11:0] ofs_i,
	output logic      [3:0]  peak_amp_o,
	output logic      [11:0] freq_sample_o,
	output logic             freq_valid_o
);
	logic [7:0] amp_nxt;
	logic [1:0] ph_r = 2'h0;
	logic       tg_r = 1'b0;
	assign amp_nxt = level_i - {3'h0, atten_step_i, 1'b0};
	// two amplitude units lost per 6 db step
	always_ff @(posedge clk_i)
	begin
		if (level_i <= {3'h0, atten_step_i, 1'b0})
			peak_amp_o <= 4'h0;
		else if (amp_nxt > 8'h0F)
			peak_amp_o <= 4'hF;
		else
			peak_amp_o <= amp_nxt[3:0];
	end
	// tones at offset plus and minus deviation, one sample in four clocks
	always_ff @(posedge clk_i)
	begin
		ph_r <= ph_r + 2'h1;
		freq_valid_o <= (ph_r == 2'h0);
		if (ph_r == 2'h0)
			tg_r <= ~tg_r;
		freq_sample_o <= tg_r ? ofs_i + 12'h0C8 : ofs_i - 12'h0C8;
	end
endmodule // rxgl_rf_model

// *** verification/rxgl_loops_test.sv ***
// self-checking bench for the rx gain and frequency loops
`timescale 1ns/10ps
module rxgl_loops_test
	import rxgl_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [5:0]  avs_address_i = 6'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'h1;
	logic [7:0]  rssi_i = 8'h80;
	logic        sync_det_i = 1'b0;
	logic [7:0]  level = 8'h00;
	logic [31:0] q;
	int          mismatches = 0;
	int          checks = 0;
	int          n;
	wire  [31:0] avs_readdata_o;
	wire         avs_waitrequest_o;
	wire         freq_valid_i;
	wire  [11:0] freq_sample_i;
	wire  [11:0] slicer_offset_o;
	wire  [11:0] if2_offset_o;
	wire  [3:0]  peak_amp_i;
	wire  [3:0]  atten_step_o;

	rxgl_loops dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .freq_sample_i(freq_sample_i),
		.freq_valid_i(freq_valid_i), .rssi_i(rssi_i), .sync_det_i(sync_det_i),
		.peak_amp_i(peak_amp_i), .slicer_offset_o(slicer_offset_o),
		.if2_offset_o(if2_offset_o), .atten_step_o(atten_step_o));
	rxgl_rf_model rf_u (.clk_i(clk_i), .atten_step_i(atten_step_o), .level_i(level),
		.ofs_i(12'h064), .peak_amp_o(peak_amp_i), .freq_sample_o(freq_sample_i),
		.freq_valid_o(freq_valid_i));

	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		chk("bus wait", 32'h2, 32'(n));
	endtask

	task rd(input logic [5:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(nm, e, q);
	endtask

	task wait_atten(input logic [3:0] v, input int lim);
		n = 0;
		while (atten_step_o !== v && n < lim)
		begin
			@(posedge clk_i);
			n++;
		end
	endtask

	task pulse_sync;
		sync_det_i <= 1'b1;
		@(posedge clk_i);
		sync_det_i <= 1'b0;
	endtask

	task t_reset;
		rd(OFS_FL_GAIN, 32'h25, "gains");
		rd(OFS_RX_CFG, 32'h4000, "rx cfg");
		rd(OFS_GL_HIGH, 32'h25, "high reg");
		rd(OFS_GL_LOW, 32'h1045, "low reg");
		rd(OFS_GL_CTRL, 32'h00C, "gain ctrl");
		bus(1'b1, 6'h24, 32'hFF, 4'hF);
		rd(6'h24, 32'h0, "unmapped");
		$display("done reset values");
	endtask

	task t_agc;
		bus(1'b1, OFS_GL_HIGH, 32'h05, 4'h1);
		bus(1'b1, OFS_GL_CTRL, 32'h01, 4'h1);
		level <= 8'h40;
		bus(1'b1, OFS_GL_CTRL, 32'h100, 4'h2);
		wait_atten(4'h8, 600);
		chk("up pace", 32'h1, 32'(n >= 84));
		repeat (100) @(posedge clk_i);
		chk("top step", 32'h8, 32'(atten_step_o));
		level <= 8'h15;
		repeat (400) @(posedge clk_i);
		chk("band hold", 32'h8, 32'(atten_step_o));
		bus(1'b1, OFS_GL_HIGH, 32'h25, 4'h1);
		level <= 8'h00;
		wait_atten(4'h7, 300);
		wait_atten(4'h6, 300);
		chk("down pace", 32'h1, 32'(n >= 60 && n <= 75));
		wait_atten(4'h0, 900);
		chk("bottom", 32'h0, 32'(atten_step_o));
		bus(1'b1, OFS_GL_CTRL, 32'h0, 4'h2);
		level <= 8'h40;
		repeat (300) @(posedge clk_i);
		chk("agc off", 32'h0, 32'(atten_step_o));
		level <= 8'h00;
		bus(1'b1, OFS_GL_CTRL, 32'h300, 4'h2);
		pulse_sync();
		level <= 8'h40;
		repeat (300) @(posedge clk_i);
		chk("frozen", 32'h0, 32'(atten_step_o));
		bus(1'b1, OFS_GL_CTRL, 32'h0, 4'h2);
		level <= 8'h00;
		$display("done gain loop");
	endtask

	task t_afc;
		rssi_i <= 8'h20;
		bus(1'b1, OFS_FL_PERIOD, 32'h10, 4'h1);
		bus(1'b1, OFS_FL_MODE, 32'h1, 4'h1);
		repeat (50) @(posedge clk_i);
		rd(OFS_STATUS, 32'h10, "below rssi");
		rssi_i <= 8'h80;
		repeat (600) @(posedge clk_i);
		chk("slicer on", 32'h1, 32'(slicer_offset_o != 12'h0));
		chk("if2 off", 32'h0, 32'(if2_offset_o));
		bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk("slow phase", 32'h4, 32'(q[6:4]));
		bus(1'b0, OFS_FL_EST, 32'h0, 4'hF);
		chk("estimate", 32'h1, 32'(q >= 32'h50 && q <= 32'h78));
		bus(1'b1, OFS_FL_MODE, 32'h3, 4'h1);
		repeat (4) @(posedge clk_i);
		chk("slicer idle", 32'h0, 32'(slicer_offset_o));
		chk("if2 on", 32'h1, 32'(if2_offset_o != 12'h0));
		bus(1'b1, OFS_RX_CFG, 32'h4, 4'h1);
		repeat (4) @(posedge clk_i);
		chk("ask if2", 32'h0, 32'(if2_offset_o));
		bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk("ask idle", 32'h1, 32'(q[6:4]));
		bus(1'b1, OFS_RX_CFG, 32'h3, 4'h1);
		bus(1'b1, OFS_FL_MODE, 32'h0, 4'h1);
		repeat (4) @(posedge clk_i);
		chk("off slicer", 32'h0, 32'(slicer_offset_o));
		bus(1'b1, OFS_FL_PERIOD, 32'h0, 4'h1);
		bus(1'b1, OFS_FL_MODE, 32'h1, 4'h1);
		repeat (200) @(posedge clk_i);
		bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk("fast until sync", 32'h2, 32'(q[6:4]));
		pulse_sync();
		repeat (4) @(posedge clk_i);
		bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk("slow on sync", 32'h4, 32'(q[6:4]));
		$display("done frequency loop");
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		wrap_up();
	end

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_agc();
		t_afc();
		wrap_up();
	end
endmodule // rxgl_loops_test
